// File: rtl/ptimer_defines.vh
`ifndef PTIMER_DEFINES_VH
`define PTIMER_DEFINES_VH

// ************************************************************
// register byte offsets on the ahb-lite slave
// ************************************************************
`define OFF_CTRL 12'h000
`define OFF_CNT 12'h004
`define OFF_CMPA 12'h008
`define OFF_CMPP 12'h00C
`define OFF_FLAGS 12'h010

// ************************************************************
// control register field positions
// ************************************************************
`define F_OSEL_LO 0
`define F_OSEL_HI 1
`define F_MODE_LO 2
`define F_MODE_HI 3
`define F_RUN 4
`define F_CCLR 5
`define F_OCINIT 6
`define F_OINV 7
`define F_CAPTS 8
`define F_CKEDGE 9

// ************************************************************
// flag register field positions
// ************************************************************
`define F_FLAG_A 0
`define F_FLAG_P 1
`define F_FLAG_IRQ 2

// ************************************************************
// mode and output select encodings
// ************************************************************
`define MODE_CMP 2'h0
`define MODE_CAP 2'h1
`define MODE_PWM 2'h2
`define MODE_TMR 2'h3
`define OSEL_0 2'h0
`define OSEL_1 2'h1
`define OSEL_2 2'h2
`define OSEL_3 2'h3

// ************************************************************
// reset values
// ************************************************************
`define CTRL_RST 10'h000
`define CNT_RST 10'h000

`endif

// File: rtl/pin_sync.v
`timescale 1ns/10ps
// ************************************************************
// two flop synchroniser with edge detect on the second stage
// ************************************************************
module pin_sync (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire pin,
    output reg level_q,
    output wire rise,
    output wire fall
);
    reg meta_q; // first stage, read only by the second
    reg last_q; // previous synchronised level

    // sample the pin twice then remember the last level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
            last_q <= 1'b0;
        end else if (ce) begin
            meta_q <= pin;
            level_q <= meta_q;
            last_q <= level_q;
        end
    end

    assign rise = ce & level_q & ~last_q;
    assign fall = ce & ~level_q & last_q;
endmodule

// File: rtl/tick_gen.v
`timescale 1ns/10ps
// ************************************************************
// timer clock enable: system clock divided by a power of two, or the external pin edge
// ************************************************************
module tick_gen #(
    parameter DIV_LOG2 = 2
) (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire [1:0] sel,
    input wire ext_tick,
    output wire tick
);
    reg [7:0] div_q; // free running prescaler

    // prescaler advances on every enabled system clock
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 8'h00;
        end else if (ce) begin
            div_q <= div_q + 8'h01;
        end
    end

    // sel: 0 system clock, 1 divided, 2 slow divided, 3 external pin edge
    assign tick = !ce ? 1'b0 :
        (sel == 2'h0) ? 1'b1 :
        (sel == 2'h1) ? (div_q[DIV_LOG2-1:0] == {DIV_LOG2{1'b1}}) :
        (sel == 2'h2) ? (div_q == 8'hFF) : ext_tick;
endmodule

// File: rtl/periodic_timer_pulse_capture.v
`timescale 1ns/10ps
`include "ptimer_defines.vh"
module periodic_timer_pulse_capture #(
    parameter CW = 10,
    parameter DIV_LOG2 = 2
) (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire external_timer_clock_pin,
    input wire capture_input_pin,
    output reg timer_out,
    output reg timer_out_en,
    output reg irq_req
);
    // ************************************************************
    // storage
    // ************************************************************
    reg [9:0] ctrl_q; // timer_control_one plus clock pin edge select
    reg [1:0] clk_sel_q; // counter clock source select
    reg [CW-1:0] cnt_q; // counter
    reg [CW-1:0] cmp_a_q; // compare_a_value
    reg [CW-1:0] cmp_p_q; // compare_p_value
    reg compare_a_flag_q; // sticky compare a flag
    reg compare_p_flag_q; // sticky compare p flag
    reg run_last_q; // run bit from previous cycle
    reg out_q; // raw waveform before polarity
    reg cap_pend_q; // capture taken, flag follows
    reg wr_q; // data phase of a write
    reg [11:0] addr_q; // address of data phase

    wire [1:0] mode_sel = {ctrl_q[`F_MODE_HI], ctrl_q[`F_MODE_LO]};
    wire [1:0] out_sel = {ctrl_q[`F_OSEL_HI], ctrl_q[`F_OSEL_LO]};
    wire run_bit = ctrl_q[`F_RUN];
    wire counter_clear_select = ctrl_q[`F_CCLR];
    wire output_initial_level = ctrl_q[`F_OCINIT];
    wire output_invert = ctrl_q[`F_OINV];
    wire capture_source_select = ctrl_q[`F_CAPTS];

    wire is_pwm = (mode_sel == `MODE_PWM) && (out_sel != `OSEL_3);
    wire is_single = (mode_sel == `MODE_PWM) && (out_sel == `OSEL_3);
    wire is_cap = (mode_sel == `MODE_CAP);

    // ************************************************************
    // pin synchronisers and timer tick
    // ************************************************************
    wire ck_rise, ck_fall, ci_rise, ci_fall, tick; // synchronised pin edges, timer tick

    // only the edges matter here, so the synchronised levels stay unconnected
    pin_sync u_ck_sync (
        .hclk(hclk), .hresetn(hresetn), .ce(clk_en),
        .pin(external_timer_clock_pin), .level_q(), .rise(ck_rise), .fall(ck_fall)
    );
    pin_sync u_ci_sync (
        .hclk(hclk), .hresetn(hresetn), .ce(clk_en),
        .pin(capture_input_pin), .level_q(), .rise(ci_rise), .fall(ci_fall)
    );

    // active clock pin edge, rising or falling by control bit
    wire ck_edge = ctrl_q[`F_CKEDGE] ? ck_fall : ck_rise;

    tick_gen #(.DIV_LOG2(DIV_LOG2)) u_tick (
        .hclk(hclk), .hresetn(hresetn), .ce(clk_en),
        .sel(clk_sel_q), .ext_tick(ck_edge), .tick(tick)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // compare against a period register, zero meaning full range
    function match_at;
        input [CW-1:0] value;
        input [CW-1:0] period;
        begin
            match_at = (period == {CW{1'b0}}) ? (value == {CW{1'b0}}) : (value == period);
        end
    endfunction

    // ************************************************************
    // counter and comparators
    // ************************************************************
    wire run_rise = run_bit & ~run_last_q;
    wire [CW-1:0] cnt_inc = cnt_q + {{(CW-1){1'b0}}, 1'b1};
    // the cycle of a run rise only zeroes the counter, counting starts after it
    wire count_now = tick & run_bit & ~run_rise;
    wire match_p = count_now & match_at(cnt_inc, cmp_p_q);
    wire match_a = count_now & (cnt_inc == cmp_a_q);
    wire cnt_ovf = count_now & (cnt_inc == {CW{1'b0}});

    // capture edge by output select, 11 disables capture
    wire src_rise = capture_source_select ? ck_rise : ci_rise;
    wire src_fall = capture_source_select ? ck_fall : ci_fall;
    reg cap_edge;
    always @* begin
        case (out_sel)
            `OSEL_0: cap_edge = src_rise;
            `OSEL_1: cap_edge = src_fall;
            `OSEL_2: cap_edge = src_rise | src_fall;
            default: cap_edge = 1'b0;
        endcase
    end
    wire cap_take = is_cap & run_bit & cap_edge;

    // which clear source applies per mode
    reg clear_now;
    always @* begin
        if (is_pwm || is_cap) begin
            clear_now = match_p;
        end else if (is_single) begin
            clear_now = 1'b0;
        end else if (counter_clear_select) begin
            clear_now = match_a;
        end else begin
            clear_now = match_p;
        end
    end

    // counter state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= `CNT_RST;
            run_last_q <= 1'b0;
        end else if (clk_en) begin
            run_last_q <= run_bit;
            if (run_rise) begin
                cnt_q <= `CNT_RST;
            end else if (clear_now) begin
                cnt_q <= {CW{1'b0}};
            end else if (count_now) begin
                cnt_q <= cnt_inc;
            end
        end
    end

    // ************************************************************
    // output waveform
    // ************************************************************
    // pwm: high from period start until duty match, stays if duty >= period
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= 1'b0;
        end else if (clk_en) begin
            if (is_single) begin
                out_q <= run_bit & ~match_a;
            end else if (is_pwm) begin
                if (run_rise || match_p) begin
                    out_q <= (cmp_a_q != {CW{1'b0}});
                end else if (match_a && (cmp_a_q < cmp_p_q || cmp_p_q == {CW{1'b0}})) begin
                    out_q <= 1'b0;
                end
            end else begin
                out_q <= 1'b0;
            end
        end
    end

    // pin drive: fixed levels for 00/01, waveform otherwise
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_out <= 1'b0;
            timer_out_en <= 1'b0;
        end else if (clk_en) begin
            timer_out_en <= (is_pwm | is_single) & ~is_cap;
            case (out_sel)
                `OSEL_0: timer_out <= 1'b0 ^ output_invert;
                `OSEL_1: timer_out <= 1'b1 ^ output_invert;
                default: timer_out <= (out_q ^ ~output_initial_level) ^ output_invert;
            endcase
        end
    end

    // ************************************************************
    // flags, capture latch and interrupt
    // ************************************************************
    wire bus_wr_flags = wr_q && (addr_q == `OFF_FLAGS);
    wire set_a = (match_a & ~is_cap) | cap_pend_q;
    // compare p plays no part in single pulse mode, so its flag stays quiet there
    wire set_p = (match_p | cnt_ovf) & ~is_single;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_a_flag_q <= 1'b0;
            compare_p_flag_q <= 1'b0;
            cap_pend_q <= 1'b0;
            irq_req <= 1'b0;
        end else if (clk_en) begin
            cap_pend_q <= cap_take;
            // write one to clear; a new event wins over the clear
            if (set_a) begin
                compare_a_flag_q <= 1'b1;
            end else if (bus_wr_flags && hwdata[`F_FLAG_A]) begin
                compare_a_flag_q <= 1'b0;
            end
            if (set_p) begin
                compare_p_flag_q <= 1'b1;
            end else if (bus_wr_flags && hwdata[`F_FLAG_P]) begin
                compare_p_flag_q <= 1'b0;
            end
            irq_req <= compare_a_flag_q | compare_p_flag_q;
        end
    end

    // ************************************************************
    // ahb-lite slave, zero wait, always okay
    // ************************************************************
    wire take = hsel & hready & htrans[1];

    // ready and response never move: zero wait states, always okay
    // address phase capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_q <= take & hwrite;
            addr_q <= haddr;
        end
    end

    // control, compare registers and hardware updates to them
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `CTRL_RST;
            clk_sel_q <= 2'h0;
            cmp_a_q <= {CW{1'b0}};
            cmp_p_q <= {CW{1'b0}};
        end else if (clk_en) begin
            if (wr_q && addr_q == `OFF_CTRL) begin
                ctrl_q <= hwdata[9:0];
                clk_sel_q <= hwdata[17:16];
            end
            if (is_single && (ck_edge && !capture_source_select)) begin
                ctrl_q[`F_RUN] <= 1'b1;
            end
            if (is_single && match_a) begin
                ctrl_q[`F_RUN] <= 1'b0;
            end
            if (wr_q && addr_q == `OFF_CMPP) begin
                cmp_p_q <= hwdata[CW-1:0];
            end
            if (cap_take) begin
                cmp_a_q <= cnt_q;
            end else if (wr_q && addr_q == `OFF_CMPA) begin
                cmp_a_q <= hwdata[CW-1:0];
            end
        end
    end

    // read data registered for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (clk_en && take && !hwrite) begin
            case (haddr)
                `OFF_CTRL: hrdata <= {14'h0000, clk_sel_q, 6'h00, ctrl_q};
                `OFF_CNT: hrdata <= {22'h000000, cnt_q};
                `OFF_CMPA: hrdata <= {22'h000000, cmp_a_q};
                `OFF_CMPP: hrdata <= {22'h000000, cmp_p_q};
                `OFF_FLAGS: hrdata <= {29'h00000000, irq_req, compare_p_flag_q, compare_a_flag_q};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// File: bench/ptimer_properties.sv
`timescale 1ns/10ps
`include "ptimer_defines.vh"
// ************************************************************
// port checker for the periodic timer
// ************************************************************
module ptimer_properties (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire timer_out,
    input wire timer_out_en
);
    reg wr_q, rd_q, last_q, seen_q; // bus phases, output history
    reg [11:0] a_q; // address of the data phase
    reg [17:0] ctl_q; // shadow of the control register
    reg [9:0] pa_q, pp_q; // shadows of the compare values
    reg [7:0] age_q; // cycles since the last write, saturating
    reg [10:0] hi_q, per_q; // high run length, cycles since a rise
    wire pwm_run = ctl_q[4:0] == 5'h1A && ctl_q[7:6] == 2'h1 && ctl_q[17:16] == 2'h0;
    // ************************************************************
    // shadows and counters
    // ************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_q, rd_q, last_q, seen_q, a_q, ctl_q, pa_q, pp_q} <= 0;
            {age_q, hi_q, per_q} <= 0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            a_q <= haddr;
            age_q <= wr_q ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
            if (wr_q && a_q == `OFF_CTRL) ctl_q <= hwdata[17:0];
            if (wr_q && a_q == `OFF_CMPA) pa_q <= hwdata[9:0];
            if (wr_q && a_q == `OFF_CMPP) pp_q <= hwdata[9:0];
            last_q <= timer_out;
            hi_q <= timer_out ? hi_q + 11'h001 : 11'h000;
            per_q <= (timer_out && !last_q) ? 11'h001 : per_q + 11'h001;
            seen_q <= !wr_q && (seen_q || (timer_out && !last_q));
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_ready_a: assert property (hreadyout) else $error("ready low");
    resp_okay_a: assert property (!hresp) else $error("error response");
    unmapped_zero_a: assert property (rd_q && a_q > `OFF_FLAGS |-> hrdata == 32'h0) else $error("unmapped data");
    count_width_a: assert property (rd_q && a_q == `OFF_CNT |-> hrdata[31:10] == 22'h0)
        else $error("counter too wide");
    pwm_period_a: assert property (pwm_run && seen_q && $rose(timer_out) && (pa_q < pp_q || pp_q == 10'h000)
        |-> per_q == (pp_q == 10'h000 ? 11'h400 : {1'b0, pp_q})) else $error("pwm period");
    pwm_duty_a: assert property (pwm_run && seen_q && $fell(timer_out) && (pa_q < pp_q || pp_q == 10'h000)
        |-> hi_q == {1'b0, pa_q}) else $error("pwm duty");
    full_duty_a: assert property (pwm_run && age_q > 8'h03 && pp_q != 10'h000 && pa_q >= pp_q |-> timer_out)
        else $error("duty not full");
    pulse_width_a: assert property (ctl_q[3:0] == 4'hB && ctl_q[7:6] == 2'h1 && age_q > 8'h03
        && $fell(timer_out) |-> hi_q == {1'b0, pa_q}) else $error("pulse width");
    pwm_enable_a: assert property (ctl_q[3:2] == 2'h2 && age_q > 8'h02 |-> timer_out_en)
        else $error("output off");
    capture_noout_a: assert property (ctl_q[3:2] == 2'h1 && age_q > 8'h02 |-> !timer_out_en)
        else $error("capture drives");
    cover property (pwm_run && seen_q && $rose(timer_out));
    cover property (ctl_q[3:0] == 4'hB && $fell(timer_out));
    cover property (ctl_q[3:2] == 2'h1 && rd_q && a_q == `OFF_FLAGS);
endmodule
bind periodic_timer_pulse_capture ptimer_properties ptimer_properties_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_out(timer_out), .timer_out_en(timer_out_en));

// File: bench/pin_source.sv
`timescale 1ns/10ps
// ************************************************************
// external pulse sources for the clock and capture pins
// ************************************************************
module pin_source (
    input wire hclk,
    output reg ck_pin,
    output reg cap_pin
);
    // both pins rest low
    initial begin
        ck_pin = 1'b0;
        cap_pin = 1'b0;
    end
    // set one pin, then keep it for hold cycles
    task automatic drive(input logic which, input logic lvl, input int hold);
        @(posedge hclk);
        if (which) ck_pin <= lvl;
        else cap_pin <= lvl;
        repeat (hold) @(posedge hclk);
    endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
`include "ptimer_defines.vh"
module tb_top;
    // ************************************************************
    // signals
    // ************************************************************
    reg hclk, hresetn, hsel, hwrite, rd_q;
    reg [11:0] haddr;
    reg [1:0] htrans, osel;
    reg [31:0] hwdata, ctl, eh;
    wire [31:0] hrdata;
    wire hreadyout, hresp, ck_pin, cap_pin, timer_out, timer_out_en, irq_req;
    int fail_count, n_tests, per;
    logic [63:0] exp_q[$], e; // expected value and mask per read
    logic [12:0] h; // high cycles counted
    logic [9:0] p, a, pp, aa;
    periodic_timer_pulse_capture periodic_timer_pulse_capture_i (.hclk(hclk), .hresetn(hresetn),
        .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .external_timer_clock_pin(ck_pin), .capture_input_pin(cap_pin), .timer_out(timer_out),
        .timer_out_en(timer_out_en), .irq_req(irq_req));
    pin_source pin_i (.hclk(hclk), .ck_pin(ck_pin), .cap_pin(cap_pin));
    // ************************************************************
    // compare, verdict and bus tasks
    // ************************************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one edge, then wait for ready under a bound
    task automatic wait_rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) begin
                fail_count++;
                results;
            end
            @(posedge hclk);
        end
    endtask
    task automatic xfer(input logic [11:0] ad, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(ad, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] x, input logic [31:0] m);
        exp_q.push_back({x, m});
        xfer(ad, 1'b0, 32'h0);
    endtask
    task automatic cnt_hi(input int n);
        h = 0;
        repeat (n) begin
            @(posedge hclk);
            h = h + timer_out;
        end
    endtask
    // read data checked at the edge that ends each data phase
    always @(posedge hclk) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            check("hrdata", hrdata & e[31:0], e[63:32] & e[31:0]);
        end
        rd_q <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = 0;
        fail_count = 0;
        n_tests = 0;
        void'($urandom(32'hFBAC));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wr(12'h040 + 12'($urandom_range(15) * 4), $urandom);
        rd(`OFF_CTRL, 32'h0, 32'hFFFFFFFF);
        rd(`OFF_CNT, 32'h0, 32'hFFFFFFFF);
        rd(12'h020 + 12'($urandom_range(15) * 4), 32'h0, 32'hFFFFFFFF);
        // pwm cases: duty, inverted, full, zero period, forced levels, divided tick, low initial level
        p = 10'($urandom_range(20, 4));
        a = 10'($urandom_range(p - 1, 1));
        for (int i = 0; i < 8; i++) begin
            pp = (i == 3) ? 10'h000 : p;
            aa = (i == 2) ? p + 10'h001 : (i == 3) ? 10'h100 : a;
            osel = (i == 4) ? 2'h0 : (i == 5) ? 2'h1 : 2'h2;
            per = (i == 3) ? 1024 : (i == 6) ? 4 * p : p; // prescaler of four at i == 6
            eh = (i == 4) ? 0 : (i == 1) ? 4 * (p - a) : (i == 0 || i == 7) ? 4 * a : (i == 6) ? 16 * a
                : (i == 3) ? 1024 : 4 * p;
            ctl = ((i == 7) ? 32'hA8 : 32'h68) | osel | ((i == 1) ? 32'h80 : 32'h0);
            ctl = ctl | ((i == 6) ? 32'h10000 : 32'h0);
            wr(`OFF_CMPP, pp);
            wr(`OFF_CMPA, aa);
            wr(`OFF_CTRL, ctl);
            wr(`OFF_CTRL, ctl | 32'h10);
            repeat (2 * per) @(posedge hclk);
            cnt_hi(4 * per);
            check("pwm high", h, eh);
        end
        // single pulse by run write, then by the clock pin
        a = 10'($urandom_range(20, 6));
        wr(`OFF_CMPP, 32'h2);
        wr(`OFF_CMPA, a);
        wr(`OFF_CTRL, 32'h4B);
        wr(`OFF_FLAGS, 32'h3);
        for (int i = 0; i < 2; i++) begin
            if (i) pin_i.drive(1'b1, 1'b1, 0);
            else wr(`OFF_CTRL, 32'h5B);
            cnt_hi(40);
            check("pulse", h, a);
            rd(`OFF_CTRL, 32'h0, 32'h10);
            rd(`OFF_FLAGS, 32'h5, 32'h7);
            check("irq_req", {31'h0, irq_req}, 32'h1);
            wr(`OFF_FLAGS, 32'h3);
            pin_i.drive(1'b1, 1'b0, 2);
        end
        wr(`OFF_CMPA, 32'h3FF);
        wr(`OFF_CTRL, 32'h5B);
        repeat (5) @(posedge hclk);
        wr(`OFF_CTRL, 32'h4B);
        repeat (2) @(posedge hclk);
        cnt_hi(20);
        check("pulse end", h, 0);
        // capture on every edge choice from both pins, clock from hclk
        wr(`OFF_CMPP, 32'h0);
        for (int i = 0; i < 8; i++) begin
            ctl = 32'hF4 | i[1:0] | (i[2] << 8);
            wr(`OFF_CTRL, ctl & 32'hEF);
            wr(`OFF_CTRL, ctl);
            wr(`OFF_FLAGS, 32'h3);
            pin_i.drive(i[2], 1'b1, 6);
            rd(`OFF_FLAGS, (i[1:0] == 2'h0 || i[1:0] == 2'h2) ? 32'h1 : 32'h0, 32'h1);
            wr(`OFF_FLAGS, 32'h1);
            pin_i.drive(i[2], 1'b0, 6);
            rd(`OFF_FLAGS, (i[1:0] == 2'h1 || i[1:0] == 2'h2) ? 32'h1 : 32'h0, 32'h1);
        end
        rd(`OFF_CMPA, 32'h0, 32'hFFFFFFE0);
        wr(`OFF_CMPP, 32'h5);
        wr(`OFF_CTRL, ctl & 32'hEF);
        wr(`OFF_CTRL, ctl);
        wr(`OFF_FLAGS, 32'h3);
        repeat (20) @(posedge hclk);
        rd(`OFF_CNT, 32'h0, 32'hFFFFFFF8);
        rd(`OFF_FLAGS, 32'h6, 32'h7);
        repeat (3) @(posedge hclk);
        results;
    end
endmodule
